// ---- pkg/stcf_defines.svh ----
// offsets, field positions, reset values and timing of the two-wire command controller
// assumes a 100 MHz system clock and byte-wide register fields in 32-bit APB words
`ifndef STCF_DEFINES_SVH
`define STCF_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define STCF_REG_CTRL 8'h00
`define STCF_REG_FRAME 8'h04
`define STCF_REG_STATUS 8'h08
`define STCF_REG_BUF_IDX 8'h0c
`define STCF_REG_BUF_DATA 8'h10

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define STCF_CTRL_GO 0
`define STCF_CTRL_OP_LO 1
`define STCF_CTRL_OP_HI 2
`define STCF_CTRL_AT 3
`define STCF_CTRL_POLL 4
`define STCF_CTRL_ABORT 5
`define STCF_ST_BUSY 0
`define STCF_ST_DONE 1
`define STCF_ST_NACK 2
`define STCF_ST_TMO 3
`define STCF_ST_REFUSED 4
`define STCF_FRAME_RESET 32'h0000_0000

// ----------------------------------------
// timing
// ----------------------------------------
`define STCF_CLK_MHZ 100
`define STCF_T_SCL_NS 1000
`define STCF_T_POLL_WR_US 5000
`define STCF_T_POLL_AT_US 20000
`define STCF_T_POLL_VFY_US 10000

// ----------------------------------------
// frame limits and command low nibbles
// ----------------------------------------
`define STCF_MAX_WR 8'h10
`define STCF_MAX_WR_AT 8'h08
`define STCF_PAGE 9'h010
`define STCF_LOW_RAND 4'h1
`define STCF_LOW_SYSRD 4'h6
`define STCF_LOW_VFY_CRYPTO 4'h8
`define STCF_LOW_VFY_PWD 4'ha

`endif

// ---- pkg/stcf_pkg.sv ----
// types shared by the two-wire command controller
// assumes nothing beyond a SystemVerilog compiler
package stcf_pkg;

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_START = 6'h02,
		S_TX = 6'h04,
		S_RX = 6'h08,
		S_STOP = 6'h10,
		S_WAIT = 6'h20
	} stcf_state_t;

	typedef enum logic [1:0] {
		STCF_OP_WRITE = 2'h0,
		STCF_OP_READ = 2'h1,
		STCF_OP_RAND = 2'h2,
		STCF_OP_SET = 2'h3
	} stcf_op_t;

endpackage : stcf_pkg

// ---- src/stcf_sync.sv ----
// three-stage synchroniser for a pin input
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module stcf_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic din,
	output logic dout
);
	logic ff1;
	logic ff2;
	logic ff3;

	// a change counts only once the second and third stages agree
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ff1 <= RST_VAL;
			ff2 <= RST_VAL;
			ff3 <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			ff1 <= din;
			ff2 <= ff1;
			ff3 <= ff2;
			if (ff2 == ff3) begin
				dout <= ff3;
			end
		end
	end
endmodule : stcf_sync
`default_nettype wire

// ---- src/stcf_mem.sv ----
// byte buffer for frame data, registered read
// assumes one writer and one address per cycle
`timescale 1ns/1ps
`default_nettype none
module stcf_mem #(
	parameter int W = 8,
	parameter int D = 256,
	parameter int AW = 8
) (
	input wire logic sys_clk,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [D];

	if (D != 2 ** AW) begin : g_bad_depth
		$error("stcf_mem: depth must equal 2**AW");
	end

	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule : stcf_mem
`default_nettype wire

// ---- src/stcf_top.sv ----
// host controller for a secure serial memory on a modified two-wire bus, APB slave
// assumes open-drain pull-up on data; clock line driven push-pull by this end
// ----------------------------------------
// Contract
// - frames are command, address 1, address 2, count; random read excepted
// - random read address set by four write bytes then repeated start
// - stop ends each command; polling is start plus command byte
// - after plain write poll with any byte: 5 ms, anti-tearing 20 ms
// - after verify poll only with read commands, within 10 ms
// - no polling after reads, sets, or encrypted writes
// - bytes shift most significant bit first
// - write count at most sixteen, eight under anti-tearing
// - writes must not run past the end of a page
// - host sends checksum right after an authenticated write; this controller sends none
// - host may end a read early with nack and stop
// - host selects a zone before user zone accesses
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "stcf_defines.svh"
module stcf_top import stcf_pkg::*; #(
	parameter int QTR_CYC = `STCF_T_SCL_NS * `STCF_CLK_MHZ / 1000 / 4,
	parameter int POLL_WR_CYC = `STCF_T_POLL_WR_US * `STCF_CLK_MHZ,
	parameter int POLL_AT_CYC = `STCF_T_POLL_AT_US * `STCF_CLK_MHZ,
	parameter int POLL_VFY_CYC = `STCF_T_POLL_VFY_US * `STCF_CLK_MHZ
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n
);
	if (QTR_CYC < 1 || POLL_WR_CYC < 1 || POLL_AT_CYC < 1 || POLL_VFY_CYC < 1) begin : g_bad
		$error("stcf_top: cycle counts must be at least one");
	end

	stcf_state_t state;
	stcf_op_t op;
	logic [31:0] frame;
	logic [7:0] cmd;
	logic at_mode, poll_en, abort, polling, poll_pend, rnd2, samp, sda_s;
	logic busy, done, nack_err, tmo, refused;
	logic ev_done, ev_nack, ev_tmo, ev_ref;
	logic [31:0] qcnt, poll_tmr, lim;
	logic [1:0] ph;
	logic [3:0] bitcnt;
	logic [2:0] byte_idx;
	logic [8:0] rem, rx_expect;
	logic [7:0] shreg, dptr, buf_idx, mem_rdata, mem_wdata, mem_addr;
	logic tick, cell_end, last_rx, vfy_cmd, mem_we, apb_wr, apb_acc, go_req, abort_req, bad_frame;
	logic next_scl, next_rel;
	logic [8:0] page_end;
	logic [7:0] wlim;
	logic [31:0] rd_val;
	logic rd_err;
	logic rx_nak;
	stcf_op_t op_w;

	assign cmd = frame[7:0];
	assign busy = (state != S_IDLE);
	assign tick = busy && (qcnt == 32'(QTR_CYC - 1));
	assign cell_end = tick && (ph == 2'd3);
	// decided at the last data bit, so an abort never moves sda while scl is high
	assign last_rx = (rem == 9'h1) || abort;
	assign vfy_cmd = (cmd[3:0] == `STCF_LOW_VFY_CRYPTO) || (cmd[3:0] == `STCF_LOW_VFY_PWD);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign apb_acc = psel && penable && pready && !pslverr;
	assign apb_wr = apb_acc && pwrite;
	assign go_req = apb_wr && (paddr == `STCF_REG_CTRL) && pwdata[`STCF_CTRL_GO];
	assign abort_req = apb_wr && (paddr == `STCF_REG_CTRL) && pwdata[`STCF_CTRL_ABORT];

	always_comb begin
		rd_err = 1'b0;
		rd_val = 32'h0;
		unique case (paddr)
			`STCF_REG_CTRL: rd_val = {27'h0, poll_en, at_mode, op, 1'b0};
			`STCF_REG_FRAME: begin
				rd_val = frame;
				rd_err = pwrite && busy;
			end
			`STCF_REG_STATUS: rd_val = {16'h0, dptr, 3'h0, refused, tmo, nack_err, done, busy};
			`STCF_REG_BUF_IDX: begin
				rd_val = {24'h0, buf_idx};
				rd_err = busy;
			end
			`STCF_REG_BUF_DATA: begin
				rd_val = {24'h0, mem_rdata};
				rd_err = busy;
			end
			default: rd_err = 1'b1;
		endcase
	end

	// one wait state: answer on the second access cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= rd_err;
			prdata <= (pwrite || rd_err) ? 32'h0 : rd_val;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			frame <= `STCF_FRAME_RESET;
			buf_idx <= 8'h0;
		end else if (apb_acc) begin
			if (pwrite && paddr == `STCF_REG_FRAME) begin
				frame <= pwdata;
			end
			if (paddr == `STCF_REG_BUF_IDX && pwrite) begin
				buf_idx <= pwdata[7:0];
			end else if (paddr == `STCF_REG_BUF_DATA) begin
				buf_idx <= buf_idx + 8'h1;
			end
		end
	end

	// sticky status: a hardware set wins over a same-cycle clear
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			done <= 1'b0;
			nack_err <= 1'b0;
			tmo <= 1'b0;
			refused <= 1'b0;
		end else begin
			if (apb_wr && paddr == `STCF_REG_STATUS) begin
				done <= ev_done || (done && !pwdata[`STCF_ST_DONE]);
				nack_err <= ev_nack || (nack_err && !pwdata[`STCF_ST_NACK]);
				tmo <= ev_tmo || (tmo && !pwdata[`STCF_ST_TMO]);
				refused <= ev_ref || (refused && !pwdata[`STCF_ST_REFUSED]);
			end else begin
				done <= done || ev_done;
				nack_err <= nack_err || ev_nack;
				tmo <= tmo || ev_tmo;
				refused <= refused || ev_ref;
			end
		end
	end

	// ----------------------------------------
	// buffer and pin sampling
	// ----------------------------------------
	assign mem_addr = busy ? dptr : buf_idx;
	assign mem_we = busy ? (cell_end && state == S_RX && bitcnt == 4'd7)
		: (apb_wr && paddr == `STCF_REG_BUF_DATA);
	assign mem_wdata = busy ? {shreg[6:0], samp} : pwdata[7:0];

	stcf_mem #(.W(8), .D(256), .AW(8)) u_mem (
		.sys_clk(sys_clk),
		.we(mem_we),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	stcf_sync #(.RST_VAL(1'b1)) u_sda_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.din(sda_in),
		.dout(sda_s)
	);

	// ----------------------------------------
	// quarter-bit divider and line drive
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst || !busy) begin
			qcnt <= 32'h0;
			ph <= 2'd0;
		end else if (tick) begin
			qcnt <= 32'h0;
			ph <= ph + 2'd1;
		end else begin
			qcnt <= qcnt + 32'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			samp <= 1'b1;
		end else if (tick && ph == 2'd2) begin
			samp <= sda_s;
		end
	end

	// bits change only while the clock line is low; start and stop move data while high
	always_comb begin
		next_scl = 1'b1;
		next_rel = 1'b1;
		unique case (state)
			S_START: begin
				next_scl = (ph == 2'd1) || (ph == 2'd2);
				next_rel = (ph < 2'd2);
			end
			S_TX: begin
				next_scl = (ph == 2'd1) || (ph == 2'd2);
				next_rel = (bitcnt == 4'd8) ? 1'b1 : shreg[7];
			end
			S_RX: begin
				next_scl = (ph == 2'd1) || (ph == 2'd2);
				next_rel = (bitcnt == 4'd8) ? rx_nak : 1'b1;
			end
			S_STOP: begin
				next_scl = (ph != 2'd0);
				next_rel = (ph >= 2'd2);
			end
			S_IDLE, S_WAIT: begin
				next_scl = 1'b1;
				next_rel = 1'b1;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			scl <= 1'b1;
			sda_oe_n <= 1'b1;
			sda_out <= 1'b0;
		end else begin
			scl <= next_scl;
			sda_oe_n <= next_rel;
			sda_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// frame sequencer
	// ----------------------------------------
	assign op_w = stcf_op_t'(pwdata[`STCF_CTRL_OP_HI:`STCF_CTRL_OP_LO]);
	assign wlim = pwdata[`STCF_CTRL_AT] ? `STCF_MAX_WR_AT : `STCF_MAX_WR;
	assign page_end = {5'h0, frame[19:16]} + {1'b0, frame[31:24]};
	assign bad_frame = (op_w == STCF_OP_WRITE) && ((frame[31:24] > wlim) || (page_end > `STCF_PAGE));

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state <= S_IDLE;
			op <= STCF_OP_WRITE;
			at_mode <= 1'b0;
			poll_en <= 1'b0;
			abort <= 1'b0;
			polling <= 1'b0;
			poll_pend <= 1'b0;
			rnd2 <= 1'b0;
			bitcnt <= 4'd0;
			byte_idx <= 3'd0;
			rem <= 9'h0;
			rx_expect <= 9'h0;
			rx_nak <= 1'b0;
			shreg <= 8'h0;
			dptr <= 8'h0;
			poll_tmr <= 32'h0;
			lim <= 32'h0;
			{ev_done, ev_nack, ev_tmo, ev_ref} <= 4'h0;
		end else begin
			{ev_done, ev_nack, ev_tmo, ev_ref} <= 4'h0;
			if (abort_req) begin
				abort <= 1'b1;
			end
			if (polling) begin
				poll_tmr <= poll_tmr + 32'h1;
			end
			if (state == S_IDLE) begin
				if (go_req && bad_frame) begin
					ev_ref <= 1'b1;
				end else if (go_req) begin
					state <= S_START;
					op <= op_w;
					at_mode <= pwdata[`STCF_CTRL_AT];
					poll_en <= pwdata[`STCF_CTRL_POLL];
					// a write with the poll bit set goes on to poll after its stop, unless one of its bytes is nacked
					poll_pend <= pwdata[`STCF_CTRL_POLL] && (op_w == STCF_OP_WRITE);
					abort <= 1'b0;
					rnd2 <= 1'b0;
					dptr <= 8'h0;
					rem <= (op_w == STCF_OP_WRITE) ? {1'b0, frame[31:24]}
						: (frame[31:24] == 8'h0) ? 9'h100 : {1'b0, frame[31:24]};
					rx_expect <= (frame[31:24] == 8'h0) ? 9'h100 : {1'b0, frame[31:24]};
					lim <= pwdata[`STCF_CTRL_AT] ? 32'(POLL_AT_CYC)
						: vfy_cmd ? 32'(POLL_VFY_CYC) : 32'(POLL_WR_CYC);
				end
			end else if (cell_end) begin
				unique case (state)
					S_START: begin
						state <= S_TX;
						bitcnt <= 4'd0;
						if (polling) begin
							// verify must be polled with a read command of the same address
							shreg <= vfy_cmd ? {cmd[7:4], `STCF_LOW_SYSRD} : cmd;
						end else if (rnd2) begin
							shreg <= {cmd[7:4], `STCF_LOW_RAND};
						end else begin
							shreg <= cmd;
							byte_idx <= 3'd0;
						end
					end
					S_TX: begin
						if (bitcnt != 4'd8) begin
							bitcnt <= bitcnt + 4'd1;
							shreg <= {shreg[6:0], 1'b0};
						end else begin
							bitcnt <= 4'd0;
							if (polling) begin
								state <= S_STOP;
								if (!samp) begin
									polling <= 1'b0;
								end else if (poll_tmr >= lim) begin
									polling <= 1'b0;
									ev_tmo <= 1'b1;
								end
							end else if (rnd2) begin
								state <= samp ? S_STOP : S_RX;
								ev_nack <= samp;
							end else if (samp && !(byte_idx == 3'd3 && op == STCF_OP_RAND)) begin
								state <= S_STOP;
								ev_nack <= 1'b1;
								poll_pend <= 1'b0;
							end else if (byte_idx < 3'd3) begin
								byte_idx <= byte_idx + 3'd1;
								unique case (byte_idx)
									3'd0: shreg <= frame[15:8];
									3'd1: shreg <= frame[23:16];
									default: shreg <= frame[31:24];
								endcase
							end else if (byte_idx == 3'd3 && op == STCF_OP_READ) begin
								state <= S_RX;
							end else if (byte_idx == 3'd3 && op == STCF_OP_RAND) begin
								state <= S_START;
								rnd2 <= 1'b1;
							end else if (op == STCF_OP_WRITE && rem != 9'h0) begin
								byte_idx <= 3'd4;
								shreg <= mem_rdata;
								dptr <= dptr + 8'h1;
								rem <= rem - 9'h1;
							end else begin
								state <= S_STOP;
							end
						end
					end
					S_RX: begin
						if (bitcnt != 4'd8) begin
							bitcnt <= bitcnt + 4'd1;
							shreg <= {shreg[6:0], samp};
							if (bitcnt == 4'd7) begin
								dptr <= dptr + 8'h1;
								rem <= rem - 9'h1;
								rx_nak <= last_rx;
							end
						end else begin
							bitcnt <= 4'd0;
							if (rx_nak) begin
								state <= S_STOP;
							end
						end
					end
					S_STOP: begin
						if (polling || poll_pend) begin
							state <= S_WAIT;
							if (poll_pend) begin
								poll_tmr <= 32'h0;
							end
							polling <= 1'b1;
							poll_pend <= 1'b0;
						end else begin
							state <= S_IDLE;
							ev_done <= 1'b1;
						end
					end
					S_WAIT: state <= S_START;
					S_IDLE: state <= S_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_idle_lines: assert property (state == S_IDLE && $past(state) == S_IDLE |-> scl && sda_oe_n)
		else $error("bus not released while idle");
	a_msb_first: assert property (state == S_TX && bitcnt < 4'd8 && ph == 2'd1 |-> sda_oe_n == shreg[7])
		else $error("transmitted bit is not the top shift bit");
	a_rx_nack_last: assert property (state == S_RX && bitcnt == 4'd8 && ph == 2'd2
		&& (rem == 9'h0 || !abort) |-> sda_oe_n == (rem == 9'h0))
		else $error("read acknowledge wrong for byte position");
	a_four_bytes: assert property ($rose(state == S_RX) && !rnd2 |-> $past(byte_idx) == 3'd3)
		else $error("read data began before the fourth byte");
	a_rx_count: assert property (cell_end && state == S_RX && bitcnt == 4'd8 && rem == 9'h0 && !abort
		|-> dptr == rx_expect[7:0])
		else $error("read byte count differs from count byte");
	a_poll_byte: assert property (state == S_TX && polling && vfy_cmd && bitcnt == 4'd0
		|-> shreg == {cmd[7:4], `STCF_LOW_SYSRD})
		else $error("verify polled with a non-read command");
	a_rr_byte: assert property (state == S_TX && rnd2 && bitcnt == 4'd0 && !polling
		|-> shreg == {cmd[7:4], `STCF_LOW_RAND})
		else $error("random read byte malformed");
	a_wr_limit: assert property ($rose(state == S_START) && $past(state) == S_IDLE && op == STCF_OP_WRITE
		|-> frame[31:24] <= (at_mode ? `STCF_MAX_WR_AT : `STCF_MAX_WR))
		else $error("write launched above count limit");
	a_count_nack: assert property (cell_end && state == S_TX && bitcnt == 4'd8 && byte_idx == 3'd3
		&& op == STCF_OP_RAND && !rnd2 && !polling |=> !ev_nack && state == S_START)
		else $error("dummy write count nack aborted random read");
	a_tmo_bound: assert property (ev_tmo |-> $past(poll_tmr) >= lim)
		else $error("poll timeout before its limit");
	a_done_after_stop: assert property ($rose(done) |-> $past(state, 2) == S_STOP)
		else $error("completion without stop condition");

	c_write_poll: cover property ($fell(polling) && !ev_tmo);
	c_read_done: cover property (ev_done && op == STCF_OP_READ);
	c_rand_done: cover property (ev_done && op == STCF_OP_RAND);
	c_nack: cover property (ev_nack);
endmodule : stcf_top
`default_nettype wire

// ---- tb/stcf_dev_model.sv ----
// behavioural model of the secure serial memory at the far end of the two-wire bus
// assumes scl comes from the host and sda is the resolved line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module stcf_dev_model #(
	parameter logic [7:0] CFG = 8'hff,
	parameter int BUSY_NS = 8000,
	parameter int BUSY_AT_NS = 25000
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic deny,
	input wire logic stall,
	output logic dev_oe_n,
	output logic [7:0] last_cmd
);
	logic [7:0] mem [256];
	logic [7:0] stg [256];
	logic [7:0] sh, a1, a2, cur, ws;
	logic me, ack, snd, tx, wr, busy, at;
	int bitn, byten, wn;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i * 59 + 17);
		{dev_oe_n, me, ack, snd, tx, wr, busy, at} = 8'h80;
		{bitn, byten, wn} = 0;
		last_cmd = 8'h00;
	end
	// ----------------------------------------
	// start and stop conditions
	// ----------------------------------------
	always @(negedge sda) if (scl) begin
		{bitn, byten} = 0;
		{tx, snd} = 2'b00;
		dev_oe_n = 1;
	end
	always @(posedge sda) if (scl) begin
		tx = 0;
		dev_oe_n = 1;
		// data commits only at stop; a crypto-mode write would also need a good checksum
		if (wr) for (int i = 0; i < wn; i++) mem[8'(ws + i)] = stg[8'(ws + i)];
		// stall holds the write cycle open so the host's poll limit can run out
		if (wr) fork
			begin
				busy = 1;
				#(at ? BUSY_AT_NS : BUSY_NS);
				wait (!stall);
				busy = 0;
			end
		join_none
		wr = 0;
	end
	// ----------------------------------------
	// byte engine
	// ----------------------------------------
	always @(posedge scl) begin
		if (bitn < 8) begin
			sh = {sh[6:0], sda};
			bitn++;
			if (bitn == 8 && !tx) begin
				ack = me;
				case (byten)
					0: begin
						last_cmd = sh;
						me = (sh[7:4] == 4'hb || sh[7:4] == CFG[3:0]) && !busy;
						ack = me;
						snd = me && sh[0];
					end
					1: a1 = sh;
					2: a2 = sh;
					3: begin
						ack = me && !deny;
						snd = ack && (last_cmd[3:0] == 4'h2 || last_cmd[3:0] == 4'h6);
						if (last_cmd[3:0] == 4'h4 && a1 == 8'h0b) at = 1;
						if (last_cmd[3:0] == 4'h4 && a1 == 8'h03) at = 0;
						ws = a2;
						wn = 0;
					end
					default: begin
						stg[a2] = sh;
						a2 = a2 + 8'h01;
						wn++;
						wr = me;
					end
				endcase
				byten++;
			end
		end else begin
			bitn = 0;
			if (tx) begin
				tx = !sda;
				a2 = {a2[7:5], a2[4:0] + 5'd1};
				cur = mem[a2];
			end else if (snd && ack) begin
				tx = 1;
				snd = 0;
				cur = mem[a2];
			end
		end
	end
	always @(negedge scl) begin
		if (bitn == 8 && !tx) dev_oe_n = !ack;
		else if (tx && bitn < 8) dev_oe_n = cur[7 - bitn];
		else dev_oe_n = 1;
	end
endmodule : stcf_dev_model
`default_nettype wire

// ---- tb/stcf_top_test.sv ----
// self-checking bench for the two-wire command controller
// assumes tb/stcf_dev_model.sv as the far end and a pull-up on the data line
`timescale 1ns/1ps
`default_nettype none
`include "stcf_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module stcf_top_test import stcf_pkg::*;;
	logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, deny = 0, stall = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q, st;
	logic pready, pslverr, scl, sda_out, sda_oe_n, dev_oe_n, slv;
	logic [7:0] last_cmd;
	logic [7:0] exp_m [256];
	int err_total = 0, comparisons = 0, seed = 32'hd9226f87;
	wire logic sda_w = (sda_oe_n | sda_out) & dev_oe_n;
	always #5 sys_clk = ~sys_clk;
	stcf_top #(.QTR_CYC(2), .POLL_WR_CYC(2000), .POLL_AT_CYC(3000), .POLL_VFY_CYC(2500))
	stcf_top_inst (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
	stcf_dev_model stcf_dev_model_inst (.scl(scl), .sda(sda_w), .deny(deny), .stall(stall),
		.dev_oe_n(dev_oe_n), .last_cmd(last_cmd));
	// ----------------------------------------
	// bus tasks and expectations
	// ----------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) err_total++;
		q = prdata;
		slv = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	function automatic logic [31:0] cw(stcf_op_t op, logic at, logic poll);
		return {27'h0, poll, at, op, 1'b1};
	endfunction : cw
	// the model's zones are 32 bytes, so sequential reads wrap inside them
	function automatic logic [7:0] nxt(logic [7:0] a);
		return {a[7:5], a[4:0] + 5'd1};
	endfunction : nxt
	task automatic wait_done();
		int n = 0;
		do begin
			apb(0, `STCF_REG_STATUS, 0);
			n++;
		end while (q[1] !== 1'b1 && q[4] !== 1'b1 && n < 9000);
		if (q[1] !== 1'b1 && q[4] !== 1'b1) err_total++;
		st = q;
		apb(1, `STCF_REG_STATUS, 32'h1e);
	endtask : wait_done
	task automatic run(input logic [31:0] frame, input logic [31:0] ctrl);
		apb(1, `STCF_REG_FRAME, frame);
		apb(1, `STCF_REG_CTRL, ctrl);
		wait_done();
	endtask : run
	task automatic fill(input logic [7:0] a, input int n);
		logic [7:0] d;
		apb(1, `STCF_REG_BUF_IDX, 0);
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			exp_m[8'(a + i)] = d;
			apb(1, `STCF_REG_BUF_DATA, {24'h0, d});
		end
	endtask : fill
	task automatic chk_rd(input logic [7:0] a, input int n);
		apb(1, `STCF_REG_BUF_IDX, 0);
		for (int i = 0; i < n; i++) begin
			apb(0, `STCF_REG_BUF_DATA, 0);
			`CHK(q[7:0], exp_m[a])
			a = nxt(a);
		end
	endtask : chk_rd
	task automatic tdone(input string s);
		$display("test %s finished", s);
	endtask : tdone
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict
	initial begin
		#900_000;
		err_total++;
		give_verdict();
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		logic [7:0] a;
		int cnt, n;
		logic [3:0] nib [4];
		logic [7:0] rc [3];
		logic [7:0] ra [3];
		nib = '{4'hb, 4'hf, 4'ha, 4'h0};
		rc = '{8'd17, 8'd9, 8'd8};
		ra = '{8'h00, 8'h00, 8'h0c};
		for (int i = 0; i < 256; i++) exp_m[i] = 8'(i * 59 + 17);
		repeat (8) @(posedge sys_clk);
		srst <= 0;
		apb(0, `STCF_REG_FRAME, 0);
		`CHK(q, `STCF_FRAME_RESET)
		apb(0, 8'h20, 0);
		`CHK(slv, 1'b1)
		`CHK({scl, sda_oe_n, sda_out}, 3'b110)
		tdone("reset");
		for (int k = 0; k < 4; k++) begin
			cnt = (k == 0) ? 16 : 1 + ($unsigned($random(seed)) % 16);
			a = {4'($random(seed)), 4'($unsigned($random(seed)) % (17 - cnt))};
			fill(a, cnt);
			run({8'(cnt), a, 8'h00, 8'hb0}, cw(STCF_OP_WRITE, 0, 1));
			`CHK(st[4:1], 4'b0001)
			run({8'(cnt), a, 8'h00, 8'hb2}, cw(STCF_OP_READ, 0, 0));
			`CHK(st[15:8], 8'(cnt))
			chk_rd(a, cnt);
		end
		tdone("write_read");
		deny <= 1;
		run({8'h04, 8'h3d, 8'h00, 8'hb0}, cw(STCF_OP_RAND, 0, 0));
		`CHK(st[2], 1'b0)
		chk_rd(8'h3d, 4);
		run({8'h02, 8'h10, 8'h00, 8'hb2}, cw(STCF_OP_READ, 0, 0));
		`CHK(st[2], 1'b1)
		run({8'h01, 8'h10, 8'h00, 8'hb0}, cw(STCF_OP_WRITE, 0, 1));
		`CHK(st[2], 1'b1)
		deny <= 0;
		tdone("random_deny");
		for (int i = 0; i < 4; i++) begin
			run({8'h01, 8'h00, 8'h00, nib[i], 4'h2}, cw(STCF_OP_READ, 0, 0));
			`CHK(st[2], nib[i] != 4'hb && nib[i] != 4'hf)
		end
		for (int i = 0; i < 3; i++) begin
			run({rc[i], ra[i], 8'h00, 8'hb0}, cw(STCF_OP_WRITE, i == 1, 1));
			`CHK(st[4], 1'b1)
		end
		tdone("address_refuse");
		run({8'h00, 8'h00, 8'h0b, 8'hb4}, cw(STCF_OP_SET, 0, 0));
		`CHK(st[4:1], 4'b0001)
		fill(8'h48, 8);
		run({8'h08, 8'h48, 8'h00, 8'hb0}, cw(STCF_OP_WRITE, 1, 1));
		`CHK(st[4:1], 4'b0001)
		run({8'h00, 8'h00, 8'h03, 8'hb4}, cw(STCF_OP_SET, 0, 0));
		fill(8'h00, 16);
		run({8'h10, 8'h00, 8'h00, 8'hb8}, cw(STCF_OP_WRITE, 0, 1));
		`CHK(last_cmd, 8'hb6)
		`CHK(st[4:1], 4'b0001)
		stall <= 1;
		fill(8'h64, 2);
		run({8'h02, 8'h64, 8'h00, 8'hb0}, cw(STCF_OP_WRITE, 0, 1));
		`CHK(st[3], 1'b1)
		stall <= 0;
		tdone("polling");
		run({8'h00, 8'h40, 8'h00, 8'hb2}, cw(STCF_OP_READ, 0, 0));
		`CHK(st[15:8], 8'h00)
		chk_rd(8'h40, 256);
		apb(1, `STCF_REG_FRAME, {8'd40, 8'h80, 8'h00, 8'hb2});
		apb(1, `STCF_REG_CTRL, cw(STCF_OP_READ, 0, 0));
		n = 0;
		do begin
			apb(0, `STCF_REG_STATUS, 0);
			n++;
		end while (q[15:8] < 8'd3 && n < 2000);
		if (q[15:8] < 8'd3) err_total++;
		apb(1, `STCF_REG_CTRL, 32'h20 | {29'h0, STCF_OP_READ, 1'b0});
		wait_done();
		`CHK(st[15:8] < 8'd40, 1'b1)
		`CHK(sda_w, 1'b1)
		tdone("long_read_abort");
		give_verdict();
	end
endmodule : stcf_top_test
`default_nettype wire
